/* File: test/cflag_engine_model.sv */
// behavioural can protocol engine: receive fifo and buffer field source
// assumes the block pops one fifo entry per rxShift pulse
`timescale 1ns/1ps
module cflag_engine_model (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic push,
  input wire logic rxShift,
  output logic msgValid,
  output logic overrun,
  output logic [1:0] pend,
  output logic [7:0] field
);
  // two-deep fifo; a push into a full fifo is lost and pulses overrun
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pend <= 2'h0;
      overrun <= 1'b0;
    end else begin
      overrun <= push && pend == 2'h2;
      pend <= pend + 2'(push && pend != 2'h2) - 2'(rxShift && pend != 2'h0);
    end
  end
  assign msgValid = pend != 2'h0; // entry waiting behind the foreground
  assign field = 8'h5a; // fixed contents of the selected buffer field
endmodule

/* File: test/tb_top.sv */
// self-checking bench for the receive flag and abort block
// assumes an axi4-lite master here and the engine model on the far side
`timescale 1ns/1ps
module tb_top
  import cflag_pkg::*;
;
  logic clock = 0, reset_n = 0, push = 0, msgValid, ovr, awready, wready;
  logic [7:0] awaddr = 0, araddr = 0, field;
  logic awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp, pend;
  logic bvalid, arready, rvalid, rxShift, errIrq, rxIrq, txIrq, irq;
  logic [8:0] txErrCount = 0;
  logic [2:0] abortGrant;
  cflag_tx_t txIn = '0;
  logic [31:0] d;
  logic [1:0] r, b;
  int errors = 0, checksDone = 0;
  always #10 clock = ~clock;
  cflag_top DUT (.clock(clock), .reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .txErrCount(txErrCount), .rxBusState(2'h0),
    .rxIn({msgValid, ovr, 2'b00}), .txIn(txIn), .bufferField(field),
    .rxShift(rxShift), .abortGrant(abortGrant), .errIrq(errIrq),
    .rxIrq(rxIrq), .txIrq(txIrq), .irq(irq));
  cflag_engine_model ENG (.clock(clock), .reset_n(reset_n), .push(push),
    .rxShift(rxShift), .msgValid(msgValid), .overrun(ovr), .pend(pend),
    .field(field));
  // ------------------------------------------------------------
  // checking and bus tasks
  // ------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d errors %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checksDone++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // holds each channel until its own handshake, sampled at the rising
  // edge; bready and rready stay high so nothing toggles twice a step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic tb;
    int n;
    n = 0;
    tb = 0;
    awaddr <= a;
    awvalid <= 1;
    wdata <= {24'h0, v};
    wvalid <= 1;
    while (!tb && n < 40) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      tb = bvalid;
      b = bresp;
      n++;
    end
    if (!tb) begin
      errors++;
      wrap_up();
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic tr;
    int n;
    n = 0;
    tr = 0;
    araddr <= a;
    arvalid <= 1;
    while (!tr && n < 40) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 0;
      tr = rvalid;
      d = rdata;
      r = rresp;
      n++;
    end
    if (!tr) begin
      errors++;
      wrap_up();
    end
  endtask
  task automatic pause(input int c);
    repeat (c) @(posedge clock);
  endtask
  task automatic msg();
    push <= 1; pause(1); push <= 0; pause(3);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  // last step leaves bus-off again
  logic [8:0] tec [8] = '{0, 96, 97, 127, 128, 255, 256, 0};
  logic [1:0] code [8] = '{0, 0, 1, 1, 2, 2, 3, 0};
  initial begin
    pause(10); reset_n <= 1; pause(1);
    rd(CFLAG_OFS_RIER); chk(d, 0);
    rd(CFLAG_OFS_TARQ); chk(d, 0);
    rd(8'h40); chk(r, CFLAG_RESP_SLVERR);
    wr(8'h40, 8'h00); chk(b, CFLAG_RESP_SLVERR);
    for (int i = 0; i < 8; i++) begin
      txErrCount <= tec[i]; pause(3);
      rd(CFLAG_OFS_RFLG); chk(d[3:2], code[i]);
    end
    // receive full, overrun and the hold on the foreground buffer
    msg(); rd(CFLAG_OFS_RFLG); chk(d[0], 1);
    chk(rxIrq, 0); wr(CFLAG_OFS_RIER, 8'h01); pause(2); chk(rxIrq, 1);
    chk(b, CFLAG_RESP_OK);
    msg(); pause(8); chk(pend, 1);
    msg(); msg(); rd(CFLAG_OFS_RFLG); chk(d[1:0], 2'h3);
    wr(CFLAG_OFS_RIER, 8'h03); pause(2); chk(errIrq, 1);
    wr(CFLAG_OFS_RFLG, 8'h03); pause(4); chk(pend, 1);
    rd(CFLAG_OFS_RFLG); chk(d[1:0], 2'h1);
    wr(CFLAG_OFS_RFLG, 8'h01); pause(4); wr(CFLAG_OFS_RFLG, 8'h01); pause(4);
    chk(rxIrq, 0); chk(pend, 0);
    // sticky status against its mask
    rd(CFLAG_OFS_ISTAT); chk(d[2:0], 3'h7);
    chk(irq, 0); wr(CFLAG_OFS_IMASK, 8'h04); pause(2); chk(irq, 1);
    wr(CFLAG_OFS_ISTAT, 8'h3f); pause(2); chk(irq, 0);
    // initialization mode clears enables but keeps the level selects
    wr(CFLAG_OFS_RIER, 8'hff); wr(CFLAG_OFS_TIER, 8'h07);
    wr(CFLAG_OFS_CTRL, 8'h01); pause(3);
    rd(CFLAG_OFS_RIER); chk(d, CFLAG_RIER_KEEP);
    wr(CFLAG_OFS_RIER, 8'h00); rd(CFLAG_OFS_RIER); chk(d, 8'h3c);
    rd(CFLAG_OFS_TIER); chk(d, 0);
    wr(CFLAG_OFS_CTRL, 8'h00); pause(3);
    // abort held off while sending, granted after a failure
    txIn.queued[0] <= 1; txIn.started[0] <= 1; pause(1); txIn.queued[0] <= 0;
    wr(CFLAG_OFS_TIER, 8'h01); rd(CFLAG_OFS_TFLG); chk(d, 8'h06);
    chk(txIrq, 0);
    wr(CFLAG_OFS_TARQ, 8'hff); pause(5);
    rd(CFLAG_OFS_TARQ); chk(d, 8'h01);
    wr(CFLAG_OFS_TARQ, 8'h00); rd(CFLAG_OFS_TARQ); chk(d, 8'h01);
    txIn.failed[0] <= 1;
    for (int n = 0; n < 20 && abortGrant !== 3'h1; n++) @(negedge clock);
    chk(abortGrant, 3'h1);
    if (abortGrant !== 3'h1) wrap_up();
    pause(2); txIn <= '0;
    rd(CFLAG_OFS_TFLG); chk(d, 8'h07);
    rd(CFLAG_OFS_TAAK); chk(d, 8'h01);
    rd(CFLAG_OFS_TARQ); chk(d, 0);
    chk(txIrq, 1);
    // buffer field visible only when selected and empty
    wr(CFLAG_OFS_SEL, 8'h01); rd(CFLAG_OFS_FIELD); chk(d, 8'h5a);
    wr(CFLAG_OFS_FIELD, 8'h00); rd(CFLAG_OFS_FIELD); chk(d, 8'h5a);
    wr(CFLAG_OFS_SEL, 8'h00); rd(CFLAG_OFS_FIELD); chk(d, 0);
    wrap_up();
  end
endmodule

/* File: verilog/cflag_pkg.sv */
// package for the can receive flag and transmit abort block
// assumes a 32-bit axi4-lite slave and a single 50 MHz clock
package cflag_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] CFLAG_OFS_RFLG = 8'h00; // receive flag status
  localparam logic [7:0] CFLAG_OFS_RIER = 8'h04; // receive irq enable
  localparam logic [7:0] CFLAG_OFS_TARQ = 8'h08; // abort request
  localparam logic [7:0] CFLAG_OFS_TIER = 8'h0c; // transmit irq enable
  localparam logic [7:0] CFLAG_OFS_TAAK = 8'h10; // abort acknowledge
  localparam logic [7:0] CFLAG_OFS_TFLG = 8'h14; // transmit empty flags
  localparam logic [7:0] CFLAG_OFS_SEL = 8'h18; // buffer select
  localparam logic [7:0] CFLAG_OFS_FIELD = 8'h1c; // selected buffer field
  localparam logic [7:0] CFLAG_OFS_CTRL = 8'h20; // init mode control
  localparam logic [7:0] CFLAG_OFS_ISTAT = 8'h24; // sticky irq status
  localparam logic [7:0] CFLAG_OFS_IMASK = 8'h28; // irq mask

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CFLAG_NBUF = 3; // transmit buffers
  localparam logic [7:0] CFLAG_RIER_RST = 8'h00;
  localparam logic [7:0] CFLAG_RIER_KEEP = 8'h3c; // level select fields
  localparam logic [2:0] CFLAG_TX_RST = 3'h0;
  localparam logic [2:0] CFLAG_TXE_RST = 3'h7; // buffers start empty
  localparam logic [7:0] CFLAG_TEC_WARN = 8'h60; // 96
  localparam logic [7:0] CFLAG_TEC_PASSIVE = 8'h7f; // 127
  localparam int CFLAG_NEVT = 6; // sticky event bits
  localparam logic [1:0] CFLAG_RESP_OK = 2'h0;
  localparam logic [1:0] CFLAG_RESP_SLVERR = 2'h2;

  // transmitter bus states
  localparam logic [1:0] CFLAG_TX_OK = 2'h0;
  localparam logic [1:0] CFLAG_TX_WARN = 2'h1;
  localparam logic [1:0] CFLAG_TX_PASSIVE = 2'h2;
  localparam logic [1:0] CFLAG_TX_BUSOFF = 2'h3;

  // per-buffer transmit engine report
  typedef struct packed {
    logic [2:0] started; // transmission in progress per buffer
    logic [2:0] failed; // lost arbitration or error per buffer
    logic [2:0] sentOk; // sent successfully per buffer
    logic [2:0] queued; // software scheduled buffer (clears empty)
  } cflag_tx_t;

  // receive side report
  typedef struct packed {
    logic msgValid; // good message in fifo waiting
    logic overrun; // data overrun pulse
    logic statusChange; // status change pulse
    logic wakeup; // wakeup pulse
  } cflag_rx_t;

endpackage

/* File: verilog/cflag_top.sv */
// can receive flags, interrupt enables and transmit abort logic
// assumes axi4-lite master, protocol engine reports synchronous
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module cflag_top
  import cflag_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // protocol engine side
  input wire logic [8:0] txErrCount,
  input wire logic [1:0] rxBusState,
  input wire cflag_rx_t rxIn,
  input wire cflag_tx_t txIn,
  input wire logic [7:0] bufferField,
  output logic rxShift,
  output logic [2:0] abortGrant,
  output logic errIrq,
  output logic rxIrq,
  output logic txIrq,
  output logic irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [1:0] txBusState_q; // tx_bus_state field
  logic [1:0] rxState_q; // receiver status field
  logic statusChangeFlag_q; // status_change_flag
  logic wakeupFlag_q;
  logic overrunFlag_q; // overrun_flag
  logic rxFullFlag_q; // rx_full_flag
  logic [7:0] rxIrqEnable_q; // rx_interrupt_enable
  logic [2:0] txEmptyIrqEnable_q; // tx_interrupt_enable
  logic [2:0] abortRequest_q; // tx_abort_request
  logic [2:0] abortAck_q;
  logic [2:0] txBufferEmpty_q;
  logic [2:0] txBufferSelect_q;
  logic initModeRequest_q;
  logic initModeAck_q;
  logic [CFLAG_NEVT-1:0] irqStatus_q; // sticky events
  logic [CFLAG_NEVT-1:0] irqMask_q;
  logic [1:0] busCode; // combinational encoder output
  logic [2:0] abortNow; // aborts granted this cycle
  logic [2:0] txEmptySet; // buffers turning empty this cycle
  logic initMode; // both request and acknowledge high
  logic [CFLAG_NEVT-1:0] evt;

  // bus write path
  logic [7:0] wrAddr_q;
  logic awHeld_q, wHeld_q;
  logic [31:0] wrData_q;
  logic [3:0] wrStrb_q;
  logic wrFire;
  logic wrOk;

  cflag_tx_state uEncode (
    .txErrCount(txErrCount),
    .busCode(busCode)
  );

  assign initMode = initModeRequest_q & initModeAck_q;

  // ----------------------------------------------------------------
  // axi write channel
  // ----------------------------------------------------------------
  // address and data taken in either order; response after both
  assign wrFire = awHeld_q & wHeld_q & ~s_axi_bvalid;
  assign wrOk = wrStrb_q[0];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      wrAddr_q <= 8'h00;
      wrData_q <= 32'h0000_0000;
      wrStrb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CFLAG_RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        wrAddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wrData_q <= s_axi_wdata;
        wrStrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wrFire) begin
        // unmapped addresses answer slave error
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wrAddr_q > CFLAG_OFS_IMASK || wrAddr_q[1:0] != 2'h0)
                       ? CFLAG_RESP_SLVERR : CFLAG_RESP_OK;
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // init mode control
  // ----------------------------------------------------------------
  // acknowledge follows request one cycle later
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      initModeRequest_q <= 1'b0;
      initModeAck_q <= 1'b0;
    end else begin
      if (wrFire && wrOk && wrAddr_q == CFLAG_OFS_CTRL) begin
        initModeRequest_q <= wrData_q[0];
      end
      initModeAck_q <= initModeRequest_q;
    end
  end

  // ----------------------------------------------------------------
  // receive flags
  // ----------------------------------------------------------------
  // status code captured together with the change flag
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      txBusState_q <= CFLAG_TX_OK;
      rxState_q <= CFLAG_TX_OK;
      statusChangeFlag_q <= 1'b0;
      wakeupFlag_q <= 1'b0;
      overrunFlag_q <= 1'b0;
    end else begin
      if (busCode != txBusState_q) begin
        statusChangeFlag_q <= 1'b1;
        txBusState_q <= busCode;
        // leaving bus-off puts the receiver straight to ok
        if (txBusState_q == CFLAG_TX_BUSOFF) begin
          rxState_q <= CFLAG_TX_OK;
        end
      end else if (rxBusState != rxState_q) begin
        statusChangeFlag_q <= 1'b1;
        rxState_q <= rxBusState;
      end else if (wrFire && wrOk && wrAddr_q == CFLAG_OFS_RFLG &&
                   wrData_q[6]) begin
        statusChangeFlag_q <= 1'b0;
      end
      // set wins over write-one-to-clear
      if (rxIn.overrun) begin
        overrunFlag_q <= 1'b1;
      end else if (wrFire && wrOk && wrAddr_q == CFLAG_OFS_RFLG &&
                   wrData_q[1]) begin
        overrunFlag_q <= 1'b0;
      end
      if (rxIn.wakeup) begin
        wakeupFlag_q <= 1'b1;
      end else if (wrFire && wrOk && wrAddr_q == CFLAG_OFS_RFLG &&
                   wrData_q[7]) begin
        wakeupFlag_q <= 1'b0;
      end
    end
  end

  // full flag gates the fifo shift into the foreground buffer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rxFullFlag_q <= 1'b0;
      rxShift <= 1'b0;
    end else begin
      rxShift <= 1'b0;
      if (!rxFullFlag_q && rxIn.msgValid && !rxShift) begin
        rxShift <= 1'b1;
        rxFullFlag_q <= 1'b1;
      end else if (wrFire && wrOk && wrAddr_q == CFLAG_OFS_RFLG &&
                   wrData_q[0]) begin
        rxFullFlag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt enables
  // ----------------------------------------------------------------
  // level select fields are untouched by init mode
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rxIrqEnable_q <= CFLAG_RIER_RST;
      txEmptyIrqEnable_q <= CFLAG_TX_RST;
    end else if (initMode) begin
      rxIrqEnable_q <= rxIrqEnable_q & CFLAG_RIER_KEEP;
      txEmptyIrqEnable_q <= CFLAG_TX_RST;
    end else if (wrFire && wrOk && !initModeRequest_q) begin
      if (wrAddr_q == CFLAG_OFS_RIER) begin
        rxIrqEnable_q <= wrData_q[7:0];
      end
      if (wrAddr_q == CFLAG_OFS_TIER) begin
        txEmptyIrqEnable_q <= wrData_q[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // abort requests, empty and acknowledge flags
  // ----------------------------------------------------------------
  // grant only while idle on the wire or after a failed attempt
  assign abortNow = abortRequest_q & ~txBufferEmpty_q &
                    (~txIn.started | txIn.failed);
  assign txEmptySet = abortNow | (txIn.sentOk & ~txBufferEmpty_q);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      abortRequest_q <= CFLAG_TX_RST;
      abortAck_q <= CFLAG_TX_RST;
      txBufferEmpty_q <= CFLAG_TXE_RST;
      abortGrant <= CFLAG_TX_RST;
    end else begin
      abortGrant <= abortNow;
      abortAck_q <= (abortAck_q & ~txIn.queued) | abortNow;
      txBufferEmpty_q <= (txBufferEmpty_q & ~txIn.queued) |
                         txEmptySet;
      if (initMode) begin
        abortRequest_q <= CFLAG_TX_RST;
      end else begin
        // software can only set; empty flag clears
        // the empty mask goes last, so that a request written in the
        // cycle its buffer empties cannot outlive that flag
        abortRequest_q <= (abortRequest_q |
          ((wrFire && wrOk && !initModeRequest_q &&
            wrAddr_q == CFLAG_OFS_TARQ) ?
            (wrData_q[2:0] & ~txBufferEmpty_q) : CFLAG_TX_RST)) &
          ~txEmptySet;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      txBufferSelect_q <= CFLAG_TX_RST;
    end else if (wrFire && wrOk && wrAddr_q == CFLAG_OFS_SEL) begin
      txBufferSelect_q <= wrData_q[2:0];
    end
  end

  // ----------------------------------------------------------------
  // sticky interrupt status and outputs
  // ----------------------------------------------------------------
  // the state event fires on every transmit code change, whether or not the
  // change flag is already up; receiver state changes do not fire it
  assign evt = {txEmptySet & txEmptyIrqEnable_q, rxIn.overrun,
                rxFullFlag_q & rxShift, busCode != txBusState_q};

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irqStatus_q <= '0;
      irqMask_q <= '0;
    end else begin
      // hardware set wins over write-one-to-clear
      if (wrFire && wrOk && wrAddr_q == CFLAG_OFS_ISTAT) begin
        irqStatus_q <= (irqStatus_q & ~wrData_q[CFLAG_NEVT-1:0]) | evt;
      end else begin
        irqStatus_q <= irqStatus_q | evt;
      end
      if (wrFire && wrOk && wrAddr_q == CFLAG_OFS_IMASK) begin
        irqMask_q <= wrData_q[CFLAG_NEVT-1:0];
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      errIrq <= 1'b0;
      rxIrq <= 1'b0;
      txIrq <= 1'b0;
      irq <= 1'b0;
    end else begin
      errIrq <= (overrunFlag_q & rxIrqEnable_q[1]) |
                (statusChangeFlag_q & rxIrqEnable_q[6]);
      rxIrq <= rxFullFlag_q & rxIrqEnable_q[0];
      txIrq <= |(txBufferEmpty_q & txEmptyIrqEnable_q);
      irq <= |(irqStatus_q & irqMask_q);
    end
  end

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  // answer in the cycle after the address is taken
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= CFLAG_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= CFLAG_RESP_OK;
      s_axi_rdata <= 32'h0000_0000;
      unique case (s_axi_araddr)
        CFLAG_OFS_RFLG: s_axi_rdata[7:0] <= {wakeupFlag_q,
          statusChangeFlag_q, rxState_q, txBusState_q, overrunFlag_q,
          rxFullFlag_q};
        CFLAG_OFS_RIER: s_axi_rdata[7:0] <= rxIrqEnable_q;
        CFLAG_OFS_TARQ: s_axi_rdata[2:0] <= abortRequest_q;
        CFLAG_OFS_TIER: s_axi_rdata[2:0] <= txEmptyIrqEnable_q;
        CFLAG_OFS_TAAK: s_axi_rdata[2:0] <= abortAck_q;
        CFLAG_OFS_TFLG: s_axi_rdata[2:0] <= txBufferEmpty_q;
        CFLAG_OFS_SEL: s_axi_rdata[2:0] <= txBufferSelect_q;
        CFLAG_OFS_FIELD: begin
          // visible only for an empty buffer that is selected
          if (|(txBufferSelect_q & txBufferEmpty_q)) begin
            s_axi_rdata[7:0] <= bufferField;
          end
        end
        CFLAG_OFS_CTRL: s_axi_rdata[1:0] <= {initModeAck_q,
                                              initModeRequest_q};
        CFLAG_OFS_ISTAT: s_axi_rdata[CFLAG_NEVT-1:0] <= irqStatus_q;
        CFLAG_OFS_IMASK: s_axi_rdata[CFLAG_NEVT-1:0] <= irqMask_q;
        default: s_axi_rresp <= CFLAG_RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_tx_code_warn: assert property (@(posedge clock) disable iff (!reset_n)
    txErrCount > 9'd96 && txErrCount <= 9'd127 |-> busCode == 2'h1)
    else $error("warning code wrong");
  a_code_busoff: assert property (@(posedge clock) disable iff (!reset_n)
    (busCode == 2'h3) == (txErrCount > 9'd255))
    else $error("bus-off code wrong");
  a_code_follows: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(statusChangeFlag_q) |-> txBusState_q == $past(busCode) ||
    rxState_q == $past(rxBusState))
    else $error("status code not updated");
  a_overrun_set: assert property (@(posedge clock) disable iff (!reset_n)
    rxIn.overrun |=> overrunFlag_q)
    else $error("overrun lost");
  a_full_blocks: assert property (@(posedge clock) disable iff (!reset_n)
    rxFullFlag_q && !rxShift |-> ##1 !rxShift)
    else $error("shift while full");
  a_rx_irq: assert property (@(posedge clock) disable iff (!reset_n)
    rxFullFlag_q && rxIrqEnable_q[0] |=> rxIrq)
    else $error("rx irq missing");
  a_init_hold: assert property (@(posedge clock) disable iff (!reset_n)
    initMode |=> txEmptyIrqEnable_q == 3'h0 && abortRequest_q == 3'h0
    && rxIrqEnable_q[7:6] == 2'h0)
    else $error("init reset failed");
  a_level_keep: assert property (@(posedge clock) disable iff (!reset_n)
    initMode |=> rxIrqEnable_q[5:2] == $past(rxIrqEnable_q[5:2]))
    else $error("level select lost");
  a_abort_flags: assert property (@(posedge clock) disable iff (!reset_n)
    |abortNow |=> (abortAck_q & txBufferEmpty_q & $past(abortNow))
    == $past(abortNow))
    else $error("abort flags not set");
  a_abort_clear: assert property (@(posedge clock) disable iff (!reset_n)
    ##1 (abortRequest_q & txBufferEmpty_q) == 3'h0)
    else $error("request survives empty");
  a_abort_gate: assert property (@(posedge clock) disable iff (!reset_n)
    (abortNow & txIn.started & ~txIn.failed) == 3'h0)
    else $error("abort of live send");
  a_tx_irq: assert property (@(posedge clock) disable iff (!reset_n)
    |(txBufferEmpty_q & txEmptyIrqEnable_q) |=> txIrq)
    else $error("tx irq missing");

  c_rx_msg: cover property (@(posedge clock) rxShift ##[1:20] !rxFullFlag_q);
  c_abort: cover property (@(posedge clock) |abortNow);
  c_busoff_exit: cover property (@(posedge clock)
    txBusState_q == 2'h3 ##1 txBusState_q != 2'h3);
  c_irq: cover property (@(posedge clock) $rose(irq));

endmodule

/* File: verilog/cflag_tx_state.sv */
// encodes the transmit error count into a two-bit bus status code
// assumes the count is nine bits so that overflow past 255 shows
`timescale 1ns/1ps
module cflag_tx_state
  import cflag_pkg::*;
(
  input wire logic [8:0] txErrCount,
  output logic [1:0] busCode
);

  // ----------------------------------------------------------------
  // classification
  // ----------------------------------------------------------------
  // bus-off only beyond 255, passive from 128
  always_comb begin
    if (txErrCount[8]) begin
      busCode = CFLAG_TX_BUSOFF;
    end else if (txErrCount[7:0] > CFLAG_TEC_PASSIVE) begin
      busCode = CFLAG_TX_PASSIVE;
    end else if (txErrCount[7:0] > CFLAG_TEC_WARN) begin
      busCode = CFLAG_TX_WARN;
    end else begin
      busCode = CFLAG_TX_OK;
    end
  end

endmodule
